// >>> inc/pil_map.svh
// constants of the power-up image loader
// What this block does
// - load target from four flash regions
// - start flash reads right after power-up
// - send bytes by fast passive parallel
// - complete lamp lights on target done
// - user or JTAG load lights both lamps
// - program user or factory design per switches
// - switches one to three pick image
// - fourth switch open enables the controller
// - no valid user image loads factory
// - switches one to three closed first user, all open factory
// - reload button loads factory image
// - first user at 0x900000, factory 0x200000
// - reload on every power-up
`ifndef PIL_MAP_SVH
`define PIL_MAP_SVH

// flash image bases
`define PIL_FIRST_USER_BASE 24'h90_0000
`define PIL_FACTORY_BASE   24'h20_0000
`define PIL_BLANK_BYTE     8'hFF

// register byte offsets
`define PIL_CTRL_OFS       8'h00
`define PIL_STATUS_OFS     8'h04
`define PIL_IRQ_STAT_OFS   8'h08
`define PIL_IRQ_MASK_OFS   8'h0C
`define PIL_COUNT_OFS      8'h10

// control and event bits
`define PIL_CTRL_RELOAD    0
`define PIL_CTRL_FACTORY   1
`define PIL_EV_DONE        0
`define PIL_EV_ERR         1
`define PIL_EV_JTAG        2
`define PIL_EV_W           3

// timing
`define PIL_CLK_NS         4
`define PIL_NCFG_LOW_NS    2000
`define PIL_NCFG_LOW_CYC   ((`PIL_NCFG_LOW_NS + `PIL_CLK_NS - 1) / `PIL_CLK_NS)
`define PIL_FLASH_ACC_NS   90
`define PIL_FLASH_ACC_CYC  ((`PIL_FLASH_ACC_NS + `PIL_CLK_NS - 1) / `PIL_CLK_NS)
`define PIL_DCLK_HALF_CYC  2
`define PIL_DONE_TMO_US    1000
`define PIL_DONE_TMO_CYC   (`PIL_DONE_TMO_US * 1000 / `PIL_CLK_NS)

`endif

// >>> inc/pil_pkg.sv
// types of the power-up image loader
package pil_pkg;
	typedef enum logic [3:0] {
		S_IDLE, S_SEL, S_CHECK, S_NCFG, S_WAIT_ST,
		S_READ, S_SEND, S_WAIT_DONE, S_DONE, S_ERR
	} pil_state_t;
endpackage

// >>> inc/pil_link_if.sv
// request paths between sequencer, flash reader and byte sender
`timescale 1ns/1ps
interface pil_link_if;
	logic        rd_req;
	logic [23:0] rd_addr;
	logic        rd_ack;
	logic [7:0]  rd_data;
	logic        tx_req;
	logic [7:0]  tx_data;
	logic        tx_ack;
	modport ctl (output rd_req, rd_addr, tx_req, tx_data, input rd_ack, rd_data, tx_ack);
	modport rd  (input rd_req, rd_addr, output rd_ack, rd_data);
	modport tx  (input tx_req, tx_data, output tx_ack);
endinterface

// >>> core/pil_flash_rd.sv
// single byte reads from the parallel configuration flash
`timescale 1ns/1ps
`include "pil_map.svh"
module pil_flash_rd #(
	parameter int ACC_CYC = `PIL_FLASH_ACC_CYC
)(
	input  wire logic        clk,
	input  wire logic        nrst,
	pil_link_if.rd           lk,
	output logic [23:0]      flash_addr,
	output logic             flash_ce_n,
	output logic             flash_oe_n,
	input  wire logic [7:0]  flash_d
);
	logic [7:0] d_s1_reg;
	logic [7:0] d_s2_reg;
	logic       busy_reg;
	logic [7:0] cnt_reg;
	logic [7:0] data_reg;
	logic       ack_reg;

	// data pins pass two flops
	always_ff @(posedge clk) begin
		d_s1_reg <= flash_d;
		d_s2_reg <= d_s1_reg;
	end

	// access timer, capture after access plus sync
	// read on request
	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy_reg   <= 1'b0;
			cnt_reg    <= 8'h00;
			data_reg   <= 8'h00;
			ack_reg    <= 1'b0;
			flash_addr <= 24'h00_0000;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
		end else begin
			ack_reg <= 1'b0;
			if (!busy_reg && lk.rd_req) begin
				busy_reg   <= 1'b1;
				cnt_reg    <= 8'h00;
				flash_addr <= lk.rd_addr;
				flash_ce_n <= 1'b0;
				flash_oe_n <= 1'b0;
			end else if (busy_reg) begin
				if (cnt_reg == 8'(ACC_CYC + 1)) begin
					data_reg   <= d_s2_reg;
					ack_reg    <= 1'b1;
					busy_reg   <= 1'b0;
					flash_ce_n <= 1'b1;
					flash_oe_n <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
		end
	end

	assign lk.rd_ack  = ack_reg;
	assign lk.rd_data = data_reg;

	property p_rd_answer;
		@(posedge clk) disable iff (!nrst) lk.rd_req && !busy_reg |-> ##[1:40] lk.rd_ack;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("flash read not answered");
endmodule

// >>> core/pil_fpp_tx.sv
// one byte on the fast passive parallel port
`timescale 1ns/1ps
`include "pil_map.svh"
module pil_fpp_tx #(
	parameter int HALF_CYC = `PIL_DCLK_HALF_CYC
)(
	input  wire logic   clk,
	input  wire logic   nrst,
	pil_link_if.tx      lk,
	output logic        target_dclk,
	output logic [7:0]  target_data
);
	logic       busy_reg;
	logic       ph_reg;
	logic [7:0] cnt_reg;
	logic       ack_reg;

	// data out, dclk low, high, then low with ack
	// byte strobe on dclk rise
	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy_reg    <= 1'b0;
			ph_reg      <= 1'b0;
			cnt_reg     <= 8'h00;
			ack_reg     <= 1'b0;
			target_dclk <= 1'b0;
			target_data <= 8'h00;
		end else begin
			ack_reg <= 1'b0;
			if (!busy_reg && lk.tx_req) begin
				busy_reg    <= 1'b1;
				ph_reg      <= 1'b0;
				cnt_reg     <= 8'h00;
				target_dclk <= 1'b0;
				target_data <= lk.tx_data;
			end else if (busy_reg) begin
				if (cnt_reg == 8'(HALF_CYC - 1)) begin
					cnt_reg <= 8'h00;
					if (!ph_reg) begin
						target_dclk <= 1'b1;
						ph_reg      <= 1'b1;
					end else begin
						target_dclk <= 1'b0;
						busy_reg    <= 1'b0;
						ack_reg     <= 1'b1;
					end
				end else begin
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
		end
	end

	assign lk.tx_ack = ack_reg;

	property p_dclk_shape;
		@(posedge clk) disable iff (!nrst)
		lk.tx_req && !busy_reg |=> !target_dclk [*2] ##1 target_dclk [*2]
			##1 (!target_dclk && lk.tx_ack);
	endproperty
	a_dclk_shape: assert property (p_dclk_shape) else $error("dclk pulse shape wrong");
endmodule

// >>> core/pil_top.sv
// power-up image loader: sequencer, lamps and register slave
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "pil_map.svh"
module pil_top #(
	parameter logic [31:0] IMAGE_BYTES  = 32'h0010_0000,
	parameter logic [31:0] DONE_TMO_CYC = 32'(`PIL_DONE_TMO_CYC),
	parameter logic [23:0] USER1_BASE   = 24'h40_0000,
	parameter logic [23:0] USER2_BASE   = 24'h60_0000
)(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq,
	input  wire logic [3:0]  image_select_switches,
	input  wire logic        factory_reload_button_n,
	output logic [23:0]      flash_addr,
	output logic             flash_ce_n,
	output logic             flash_oe_n,
	input  wire logic [7:0]  flash_d,
	output logic             target_cfg_start_n,
	output logic             target_cfg_oe,
	output logic             target_dclk,
	output logic [7:0]       target_data,
	input  wire logic        target_status_n,
	input  wire logic        config_complete_indicator,
	output logic             config_complete_lamp,
	output logic             user_image_lamp
);
	pil_link_if lk ();

	pil_pkg::pil_state_t state_reg;
	pil_pkg::pil_state_t state_next;
	logic [6:0]  s1_reg;
	logic [6:0]  s2_reg;
	logic        btn_d_reg;
	logic        done_d_reg;
	logic [1:0]  settle_reg;
	logic        boot_pend_reg;
	logic        rld_pend_reg;
	logic        fac_pend_reg;
	logic        force_reg;
	logic        user_img_reg;
	logic [23:0] addr_reg;
	logic [31:0] cnt_reg;
	logic [31:0] tmr_reg;
	logic        rd_req_reg;
	logic        tx_req_reg;
	logic [7:0]  tx_data_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_ofs_reg;
	logic [`PIL_EV_W-1:0] ev_stat_reg;
	logic [`PIL_EV_W-1:0] ev_mask_reg;
	logic [`PIL_EV_W-1:0] ev;
	logic [2:0]  sel_s;
	logic        en_s;
	logic        btn_fall;
	logic        done_s;
	logic        status_ok;
	logic        settled;
	logic        ap_take;
	logic        soft_rld;
	logic        soft_fac;
	logic        launch;
	logic        user_sel;

	function automatic logic [23:0] img_base(input logic [2:0] sel);
		case (sel)
			3'b000:  img_base = `PIL_FIRST_USER_BASE;
			3'b001:  img_base = USER1_BASE;
			3'b010:  img_base = USER2_BASE;
			default: img_base = `PIL_FACTORY_BASE;
		endcase
	endfunction

	// switches, button and target pins pass two flops
	always_ff @(posedge clk) begin
		s1_reg <= {config_complete_indicator, target_status_n, factory_reload_button_n,
			image_select_switches};
		s2_reg <= s1_reg;
	end

	// synced views; switch open reads high
	assign sel_s     = s2_reg[2:0];
	assign en_s      = s2_reg[3];
	assign done_s    = s2_reg[6];
	assign status_ok = s2_reg[5];
	assign btn_fall  = btn_d_reg && !s2_reg[4];
	assign settled   = settle_reg == 2'b11;
	assign ap_take   = hsel && hready && htrans[1];
	assign soft_rld  = wr_pend_reg && wr_ofs_reg == `PIL_CTRL_OFS && hwdata[`PIL_CTRL_RELOAD];
	assign soft_fac  = soft_rld && hwdata[`PIL_CTRL_FACTORY];
	assign user_sel  = !(force_reg || img_base(sel_s) == `PIL_FACTORY_BASE);
	assign launch    = state_reg == pil_pkg::S_IDLE && settled && en_s &&
		(boot_pend_reg || rld_pend_reg || btn_fall || soft_rld);

	// next state of the load sequence
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pil_pkg::S_IDLE:
				if (launch) state_next = pil_pkg::S_SEL;
			pil_pkg::S_SEL:
				state_next = user_sel ? pil_pkg::S_CHECK : pil_pkg::S_NCFG;
			pil_pkg::S_CHECK:
				if (lk.rd_ack) state_next = pil_pkg::S_NCFG;
			pil_pkg::S_NCFG:
				if (tmr_reg == 32'(`PIL_NCFG_LOW_CYC - 1)) state_next = pil_pkg::S_WAIT_ST;
			pil_pkg::S_WAIT_ST:
				if (status_ok) state_next = pil_pkg::S_READ;
				else if (tmr_reg == DONE_TMO_CYC) state_next = pil_pkg::S_ERR;
			pil_pkg::S_READ:
				if (lk.rd_ack) state_next = pil_pkg::S_SEND;
			pil_pkg::S_SEND:
				if (!status_ok) state_next = pil_pkg::S_ERR;
				else if (lk.tx_ack) state_next = (cnt_reg == IMAGE_BYTES - 32'h1) ?
					pil_pkg::S_WAIT_DONE : pil_pkg::S_READ;
			pil_pkg::S_WAIT_DONE:
				if (done_s) state_next = pil_pkg::S_DONE;
				else if (tmr_reg == DONE_TMO_CYC) state_next = pil_pkg::S_ERR;
			default:
				state_next = pil_pkg::S_IDLE;
		endcase
	end

	// state, timer and request pulses
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg  <= pil_pkg::S_IDLE;
			tmr_reg    <= 32'h0000_0000;
			rd_req_reg <= 1'b0;
			tx_req_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			tmr_reg    <= (state_next != state_reg) ? 32'h0000_0000 : tmr_reg + 32'h1;
			// flash read at each read state entry
			rd_req_reg <= state_next != state_reg &&
				(state_next == pil_pkg::S_READ || state_next == pil_pkg::S_CHECK);
			tx_req_reg <= state_next == pil_pkg::S_SEND && state_reg != pil_pkg::S_SEND;
		end
	end

	// power-up and reload requests
	always_ff @(posedge clk) begin
		if (!nrst) begin
			settle_reg    <= 2'b00;
			boot_pend_reg <= 1'b1;
			rld_pend_reg  <= 1'b0;
			fac_pend_reg  <= 1'b0;
			btn_d_reg     <= 1'b1;
		end else begin
			btn_d_reg <= s2_reg[4];
			if (!settled) settle_reg <= settle_reg + 2'b01;
			// boot load with no host action
			if (settled && state_reg == pil_pkg::S_IDLE) boot_pend_reg <= 1'b0;
			if ((btn_fall || soft_rld) && !launch) begin
				rld_pend_reg <= 1'b1;
				fac_pend_reg <= fac_pend_reg || btn_fall || soft_fac;
			end else if (launch) begin
				rld_pend_reg <= 1'b0;
				fac_pend_reg <= 1'b0;
			end
		end
	end

	// image choice, address and byte count
	always_ff @(posedge clk) begin
		if (!nrst) begin
			force_reg    <= 1'b0;
			user_img_reg <= 1'b0;
			addr_reg     <= 24'h00_0000;
			cnt_reg      <= 32'h0000_0000;
			tx_data_reg  <= 8'h00;
		end else begin
			if (launch) force_reg <= fac_pend_reg || btn_fall || soft_fac;
			case (state_reg)
				pil_pkg::S_SEL: begin
					addr_reg     <= force_reg ? `PIL_FACTORY_BASE : img_base(sel_s);
					user_img_reg <= user_sel;
					cnt_reg      <= 32'h0000_0000;
				end
				pil_pkg::S_CHECK:
					if (lk.rd_ack && lk.rd_data == `PIL_BLANK_BYTE) begin
						addr_reg     <= `PIL_FACTORY_BASE;
						user_img_reg <= 1'b0;
					end
				pil_pkg::S_READ:
					if (lk.rd_ack) tx_data_reg <= lk.rd_data;
				pil_pkg::S_SEND:
					if (lk.tx_ack) begin
						addr_reg <= addr_reg + 24'h00_0001;
						cnt_reg  <= cnt_reg + 32'h1;
					end
				default: begin
				end
			endcase
		end
	end

	// configuration pins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			target_cfg_start_n <= 1'b1;
			target_cfg_oe      <= 1'b0;
		end else begin
			target_cfg_start_n <= state_next != pil_pkg::S_NCFG;
			target_cfg_oe <= state_next inside {pil_pkg::S_NCFG, pil_pkg::S_WAIT_ST,
				pil_pkg::S_READ, pil_pkg::S_SEND, pil_pkg::S_WAIT_DONE};
		end
	end

	// lamps
	always_ff @(posedge clk) begin
		if (!nrst) begin
			done_d_reg           <= 1'b0;
			config_complete_lamp <= 1'b0;
			user_image_lamp      <= 1'b0;
		end else begin
			done_d_reg <= done_s;
			config_complete_lamp <= done_s;
			if (!done_s || state_reg == pil_pkg::S_ERR)
				user_image_lamp <= 1'b0;
			else if (state_reg == pil_pkg::S_DONE)
				user_image_lamp <= user_img_reg;
			else if (state_reg == pil_pkg::S_IDLE && !done_d_reg)
				user_image_lamp <= 1'b1;
		end
	end

	// events
	assign ev[`PIL_EV_DONE] = state_reg == pil_pkg::S_DONE;
	assign ev[`PIL_EV_ERR]  = state_reg == pil_pkg::S_ERR;
	assign ev[`PIL_EV_JTAG] = state_reg == pil_pkg::S_IDLE && done_s && !done_d_reg;

	// bus slave: zero wait, read data caught in the address phase
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b0;
			hresp       <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_ofs_reg  <= 8'h00;
			ev_mask_reg <= 3'h0;
			ev_stat_reg <= 3'h0;
			irq         <= 1'b0;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= ap_take && hwrite;
			wr_ofs_reg  <= {haddr[7:2], 2'b00};
			if (wr_pend_reg && wr_ofs_reg == `PIL_IRQ_MASK_OFS)
				ev_mask_reg <= hwdata[`PIL_EV_W-1:0];
			// sticky events, set beats read clear
			ev_stat_reg <= ((ap_take && !hwrite && haddr[7:0] == `PIL_IRQ_STAT_OFS) ?
				3'h0 : ev_stat_reg) | ev;
			irq <= |(ev_stat_reg & ev_mask_reg);
			if (ap_take && !hwrite) begin
				case ({haddr[7:2], 2'b00})
					`PIL_STATUS_OFS:   hrdata <= {26'h0, en_s, user_img_reg, user_image_lamp,
						config_complete_lamp, state_reg == pil_pkg::S_ERR,
						state_reg != pil_pkg::S_IDLE};
					`PIL_IRQ_STAT_OFS: hrdata <= {29'h0, ev_stat_reg};
					`PIL_IRQ_MASK_OFS: hrdata <= {29'h0, ev_mask_reg};
					`PIL_COUNT_OFS:    hrdata <= cnt_reg;
					default:           hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign lk.rd_req  = rd_req_reg;
	assign lk.rd_addr = addr_reg;
	assign lk.tx_req  = tx_req_reg;
	assign lk.tx_data = tx_data_reg;

	pil_flash_rd u_rd (
		.clk        (clk),
		.nrst       (nrst),
		.lk         (lk),
		.flash_addr (flash_addr),
		.flash_ce_n (flash_ce_n),
		.flash_oe_n (flash_oe_n),
		.flash_d    (flash_d)
	);

	pil_fpp_tx u_tx (
		.clk         (clk),
		.nrst        (nrst),
		.lk          (lk),
		.target_dclk (target_dclk),
		.target_data (target_data)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_boot_go;
		state_reg == pil_pkg::S_IDLE && boot_pend_reg && settled && en_s |=> state_reg == pil_pkg::S_SEL;
	endproperty
	a_boot_go: assert property (p_boot_go) else $error("no load at power-up");
	property p_disabled;
		state_reg == pil_pkg::S_IDLE && !en_s |=> state_reg == pil_pkg::S_IDLE;
	endproperty
	a_disabled: assert property (p_disabled) else $error("load while disabled");
	property p_first_user;
		state_reg == pil_pkg::S_SEL && !force_reg && sel_s == 3'b000 |=>
			addr_reg == 24'h90_0000 && state_reg == pil_pkg::S_CHECK;
	endproperty
	a_first_user: assert property (p_first_user) else $error("first user base wrong");
	property p_factory;
		state_reg == pil_pkg::S_SEL && sel_s == 3'b111 |=>
			addr_reg == 24'h20_0000 && state_reg == pil_pkg::S_NCFG;
	endproperty
	a_factory: assert property (p_factory) else $error("factory base wrong");
	property p_fallback;
		state_reg == pil_pkg::S_CHECK && lk.rd_ack && lk.rd_data == 8'hFF |=>
			addr_reg == 24'h20_0000 && !user_img_reg;
	endproperty
	a_fallback: assert property (p_fallback) else $error("no factory fallback");
	property p_button;
		state_reg == pil_pkg::S_IDLE && settled && en_s && btn_fall |=> force_reg ##1
			addr_reg == 24'h20_0000;
	endproperty
	a_button: assert property (p_button) else $error("button did not force factory");
	property p_release;
		state_reg inside {pil_pkg::S_IDLE, pil_pkg::S_SEL} |-> !target_cfg_oe && target_cfg_start_n;
	endproperty
	a_release: assert property (p_release) else $error("pins driven while idle");
	property p_err_dark;
		state_reg == pil_pkg::S_ERR && !done_s |=> !user_image_lamp ##1 !config_complete_lamp;
	endproperty
	a_err_dark: assert property (p_err_dark) else $error("lamp lit after failure");

	c_done:  cover property (state_reg == pil_pkg::S_DONE && user_img_reg);
	c_err:   cover property (state_reg == pil_pkg::S_ERR);
	c_fback: cover property (state_reg == pil_pkg::S_CHECK && lk.rd_ack && lk.rd_data == 8'hFF);
	c_jtag:  cover property (ev[`PIL_EV_JTAG]);
endmodule

// >>> tb/pil_partner.sv
// flash and target device model facing the image loader
`timescale 1ns/1ps
module pil_partner (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [23:0] flash_addr,
	input  wire logic        flash_ce_n,
	input  wire logic        flash_oe_n,
	output logic [7:0]       flash_d,
	input  wire logic        target_cfg_start_n,
	input  wire logic        target_cfg_oe,
	input  wire logic        target_dclk,
	input  wire logic [7:0]  target_data,
	output logic             target_status_n,
	output logic             config_complete_indicator,
	input  wire logic [31:0] user_img,
	input  wire logic [31:0] fact_img,
	input  wire logic        blank,
	input  wire logic        done_en,
	input  wire logic        jtag_load
);
	logic [7:0] fd;
	logic       done;
	logic [7:0] rx[$];

	// byte stored at a flash address, erased bytes read 0xFF
	function automatic logic [7:0] fbyte(input logic [23:0] a);
		logic [7:0] b;
		b = 8'hFF;
		if (a[23:2] == 22'h24_0000) begin
			b = (blank && a[1:0] == 2'h0) ? 8'hFF : user_img[a[1:0]*8 +: 8];
		end
		if (a[23:2] == 22'h08_0000) begin
			b = fact_img[a[1:0]*8 +: 8];
		end
		return b;
	endfunction

	// flash drives data when selected, a toggling pattern otherwise
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fd <= 8'h00;
		end else if (!flash_ce_n && !flash_oe_n) begin
			fd <= fbyte(flash_addr);
		end else begin
			fd <= ~fd;
		end
	end
	assign flash_d = fd;

	// target takes one byte per rising byte clock
	always @(posedge target_dclk) begin
		if (target_cfg_oe) begin
			rx.push_back(target_data);
		end
	end

	// target ready once the config pulse ends
	assign target_status_n = target_cfg_start_n;

	// done lost at power-down, set by JTAG
	// config pulse wipes done and the bytes taken so far
	always @(posedge clk) begin
		if (!nrst) begin
			done <= 1'b0;
		end else if (!target_cfg_start_n && target_cfg_oe) begin
			done <= 1'b0;
			rx.delete();
		end else if (jtag_load || (done_en && rx.size() == 4)) begin
			done <= 1'b1;
		end
	end
	assign config_complete_indicator = done;
endmodule

// >>> tb/testbench.sv
// self-checking bench for the power-up image loader
`timescale 1ns/1ps
module testbench;
	logic        clk, nrst, hsel, hwrite, hreadyout, hresp, irq, btn_n;
	logic        blank, done_en, jtag_load, ce_n, oe_n, start_n, cfg_oe, dclk;
	logic        status_n, done, lamp_c, lamp_u, act;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, user_img, fact_img;
	logic [3:0]  sw;
	logic [23:0] faddr;
	logic [7:0]  fdata, tdata;
	int          n_fail, cmp_count, seed;

	// free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	pil_top #(.IMAGE_BYTES(32'h0000_0004), .DONE_TMO_CYC(32'h0000_00C8)) u_pil_top (
		.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
		.image_select_switches(sw), .factory_reload_button_n(btn_n),
		.flash_addr(faddr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_d(fdata),
		.target_cfg_start_n(start_n), .target_cfg_oe(cfg_oe), .target_dclk(dclk),
		.target_data(tdata), .target_status_n(status_n),
		.config_complete_indicator(done), .config_complete_lamp(lamp_c),
		.user_image_lamp(lamp_u));

	pil_partner u_pil_partner (
		.clk(clk), .nrst(nrst), .flash_addr(faddr), .flash_ce_n(ce_n),
		.flash_oe_n(oe_n), .flash_d(fdata), .target_cfg_start_n(start_n),
		.target_cfg_oe(cfg_oe), .target_dclk(dclk), .target_data(tdata),
		.target_status_n(status_n), .config_complete_indicator(done),
		.user_img(user_img), .fact_img(fact_img), .blank(blank),
		.done_en(done_en), .jtag_load(jtag_load));

	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// one AHB-Lite single word transfer
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	// power cycle with new switches and fresh random images
	task automatic boot(input logic [3:0] s, input logic bl, input logic de);
		nrst <= 1'b0;
		sw <= s;
		blank <= bl;
		done_en <= de;
		user_img <= $random(seed) & 32'hFFFF_FF7F;
		fact_img <= $random(seed);
		repeat (20) @(posedge clk);
		u_pil_partner.rx.delete();
		nrst <= 1'b1;
	endtask

	// wait for a load to start and to finish
	task automatic run_load;
		int i;
		for (i = 0; i < 200 && cfg_oe !== 1'b1; i++) @(posedge clk);
		chk(cfg_oe, 1'b1);
		for (i = 0; i < 4000 && cfg_oe !== 1'b0; i++) @(posedge clk);
		chk(cfg_oe, 1'b0);
		repeat (6) @(posedge clk);
	endtask

	// bytes seen by the target against the image the caller passes
	task automatic expect_img(input logic [31:0] img);
		int i;
		chk(32'(u_pil_partner.rx.size()), 32'h0000_0004);
		for (i = 0; i < 4 && i < u_pil_partner.rx.size(); i++) begin
			chk(u_pil_partner.rx[i], img[i*8 +: 8]);
		end
	endtask

	// verdict and end of run
	task conclude;
		$display("compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// watchdog against a hung load or bus
	initial begin
		#200000;
		n_fail++;
		conclude();
	end

	// test sequence
	initial begin
		{nrst, hsel, hwrite, btn_n, blank, done_en, jtag_load} = 7'h08;
		{htrans, haddr, hwdata, sw} = '0;
		{user_img, fact_img} = '0;
		{n_fail, cmp_count} = '0;
		seed = 78;
		@(posedge clk);
		boot(4'h8, 1'b0, 1'b1);
		run_load();
		expect_img(user_img);
		chk({lamp_c, lamp_u}, 2'h3);
		ahb(1'b0, 32'h0000_0004, '0, rd);
		chk(rd, 32'h0000_003C);
		ahb(1'b0, 32'h0000_0010, '0, rd);
		chk(rd, 32'h0000_0004);
		ahb(1'b0, 32'h0000_0008, '0, rd);
		chk(rd, 32'h0000_0001);
		ahb(1'b0, 32'h0000_0008, '0, rd);
		chk(rd, 32'h0000_0000);
		ahb(1'b1, 32'h0000_0000, 32'h0000_0001, rd);
		run_load();
		expect_img(user_img);
		$display("test user image finished");
		boot(4'hF, 1'b0, 1'b1);
		run_load();
		expect_img(fact_img);
		chk({lamp_c, lamp_u}, 2'h2);
		boot(4'h8, 1'b1, 1'b1);
		run_load();
		expect_img(fact_img);
		chk({lamp_c, lamp_u}, 2'h2);
		$display("test factory image finished");
		boot(4'h0, 1'b0, 1'b1);
		act = 1'b0;
		repeat (600) begin
			@(posedge clk);
			if (cfg_oe !== 1'b0 || start_n !== 1'b1) act = 1'b1;
		end
		chk(act, 1'b0);
		$display("test disabled finished");
		boot(4'h8, 1'b0, 1'b1);
		run_load();
		ahb(1'b1, 32'h0000_000C, 32'h0000_0001, rd);
		ahb(1'b0, 32'h0000_0008, '0, rd);
		ahb(1'b0, 32'h0000_0020, '0, rd);
		chk(rd, 32'h0000_0000);
		chk({hresp, hreadyout}, 2'h1);
		chk(irq, 1'b0);
		u_pil_partner.rx.delete();
		btn_n <= 1'b0;
		repeat (8) @(posedge clk);
		btn_n <= 1'b1;
		run_load();
		expect_img(fact_img);
		chk({lamp_c, lamp_u, irq}, 3'h5);
		ahb(1'b0, 32'h0000_0008, '0, rd);
		chk(rd, 32'h0000_0001);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		$display("test button and interrupt finished");
		boot(4'h8, 1'b0, 1'b0);
		run_load();
		chk({lamp_c, lamp_u}, 2'h0);
		ahb(1'b0, 32'h0000_0004, '0, rd);
		chk(rd & 32'h0000_0003, 32'h0000_0000);
		ahb(1'b0, 32'h0000_0008, '0, rd);
		chk(rd, 32'h0000_0002);
		jtag_load <= 1'b1;
		repeat (8) @(posedge clk);
		chk({lamp_c, lamp_u, cfg_oe}, 3'h6);
		$display("test timeout and jtag finished");
		conclude();
	end
endmodule
